// *** src/hlc_pkg.sv ***
package hlc_pkg;

   // register bus geometry
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;

   // span of this bank, register addresses as numbered on the bus
   localparam logic [15:0] SPAN_LO = 16'h01E5;
   localparam logic [15:0] SPAN_HI = 16'h0213;
   localparam int NUM_REGS = 47;

   // register offsets
   localparam logic [15:0] DT_RETRY_LIMIT = 16'h01E5;
   localparam logic [15:0] DT_RATE_LIMIT_EN = 16'h01E6;
   localparam logic [15:0] INVERSION_TOLERATE_TIME = 16'h01E7;
   localparam logic [15:0] INVERSION_RESPONSE = 16'h01E8;
   localparam logic [15:0] XCHG_OUTLET_DT_EN = 16'h01E9;
   localparam logic [15:0] XCHG_OUTLET_DT_DEG = 16'h01EA;
   localparam logic [15:0] XCHG_RISE_EN = 16'h01EB;
   localparam logic [15:0] RISE_RESPONSE = 16'h01EC;
   localparam logic [15:0] RISE_RETRY_LIMIT = 16'h01ED;
   localparam logic [15:0] INLET_XCHG_DT_EN = 16'h01EE;
   localparam logic [15:0] INLET_XCHG_DT_DEG = 16'h01EF;
   localparam logic [15:0] HEAT_ANTICOND_EN = 16'h01F0;
   localparam logic [15:0] HEAT_ANTICOND_SETPT = 16'h01F1;
   localparam logic [15:0] HEAT_ANTICOND_PUMP_OFF = 16'h01F2;
   localparam logic [15:0] WATER_ANTICOND_EN = 16'h01F3;
   localparam logic [15:0] WATER_ANTICOND_SETPT = 16'h01F4;
   localparam logic [15:0] WATER_ANTICOND_PUMP_OFF = 16'h01F5;
   localparam logic [15:0] ANTICOND_PRIORITY_MAP = 16'h01F6;
   localparam logic [15:0] FROST_ANTICOND_EN = 16'h01F7;
   localparam logic [15:0] WATER_STORAGE_EN = 16'h01F8;
   localparam logic [15:0] WATER_STORAGE_TIME = 16'h01F9;
   localparam logic [15:0] WATER_STORAGE_SETPT = 16'h01FA;
   localparam logic [15:0] WATER_STORAGE_ON_HYST = 16'h01FB;
   localparam logic [15:0] WATER_STORAGE_OFF_HYST = 16'h01FC;
   localparam logic [15:0] WATER_PRIORITY_METHOD = 16'h01FD;
   localparam logic [15:0] RESERVED_A_LO = 16'h01FE;
   localparam logic [15:0] RESERVED_A_HI = 16'h01FF;
   localparam logic [15:0] HEAT_CURVE_MAX_OUTDOOR = 16'h0200;
   localparam logic [15:0] HEAT_CURVE_MIN_OUTDOOR = 16'h0201;
   localparam logic [15:0] HEAT_CURVE_LOW_WATER = 16'h0202;
   localparam logic [15:0] HEAT_CURVE_BOOST_TIME = 16'h0203;
   localparam logic [15:0] HEAT_CURVE_MAX_OFF = 16'h0204;
   localparam logic [15:0] GROUP_CURVE_MAX_OUTDOOR = 16'h0205;
   localparam logic [15:0] GROUP_CURVE_MIN_OUTDOOR = 16'h0206;
   localparam logic [15:0] GROUP_CURVE_LOW_WATER = 16'h0207;
   localparam logic [15:0] GROUP_CURVE_BOOST_TIME = 16'h0208;
   localparam logic [15:0] GROUP_CURVE_MAX_OFF = 16'h0209;
   localparam logic [15:0] HEAT_CURVE_BOOST_STEP = 16'h020A;
   localparam logic [15:0] HEAT_CURVE_RECOVERY_TIME = 16'h020B;
   localparam logic [15:0] GROUP_CURVE_BOOST_STEP = 16'h020C;
   localparam logic [15:0] GROUP_CURVE_RECOVERY_TIME = 16'h020D;
   localparam logic [15:0] MIN_BOILER_WATER_TEMP = 16'h020E;
   localparam logic [15:0] GROUP_CURVE_MIN_WATER = 16'h020F;
   localparam logic [15:0] HEAT_FROST_EN = 16'h0210;
   localparam logic [15:0] WATER_FROST_EN = 16'h0211;
   localparam logic [15:0] OUTDOOR_FROST_SETPT = 16'h0212;
   localparam logic [15:0] RESERVED_B = 16'h0213;

   // reset value of every storage register
   localparam logic [15:0] REG_RESET = 16'h0000;

   // field encodings and ranges
   localparam logic [15:0] NOT_CONFIGURED = 16'hFFFF;
   localparam logic [15:0] TIME_MAX_S = 16'hFD20;     // 64800 s
   localparam logic [15:0] DIFF_MAX = 16'h0514;       // 130.0 deg in tenths
   localparam logic [15:0] TEMP_MAX = 16'h0514;       // 130.0 deg in tenths
   localparam logic [15:0] TEMP_MIN = 16'hFE70;       // -40.0 deg in tenths
   localparam logic [4:0] PRIO_MASK = 5'h1F;
   localparam int PRIO_STACK = 0;
   localparam int PRIO_DT = 1;
   localparam int PRIO_SLOW = 2;
   localparam int PRIO_RATE = 3;
   localparam int PRIO_OUTLET = 4;

   // limit response choices
   typedef enum logic [1:0] {
      HLC_RESP_LOCKOUT,
      HLC_RESP_RECYCLE,
      HLC_RESP_RECYCLE_RETRY,
      HLC_RESP_BAD
   } hlc_resp_t;

   // decoded sensor-pair check enables
   typedef struct packed {
      logic diff_check;
      logic inversion_check;
   } hlc_pair_t;

   // decoded duration
   typedef struct packed {
      logic configured;
      logic in_range;
      logic [15:0] seconds;
   } hlc_time_t;

   // register bus request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } hlc_req_t;

endpackage

// *** src/hlc_bank.sv ***
`timescale 1ns/100ps
module hlc_bank
   import hlc_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   // register access from the serial-bus front end
   input wire logic RD_I,
   input wire logic WR_I,
   input wire logic [15:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   // read answer
   output logic [15:0] RDATA_O,
   output logic RVALID_O,
   output logic HIT_O,
   // decoded settings for the thermal control
   output logic [1:0] DT_PAIR_XO_O,
   output logic [1:0] DT_PAIR_IX_O,
   output logic [1:0] INV_RESP_O,
   output logic [1:0] RISE_RESP_O,
   output logic [15:0] DT_RETRY_O,
   output logic [15:0] RISE_RETRY_O,
   output logic DT_RATE_LIMIT_O,
   output logic [4:0] ANTICOND_PRIO_O,
   output logic HEAT_PUMP_OFF_O,
   output logic WATER_PUMP_OFF_O,
   output logic WATER_PRIO_DROP_O,
   output logic [6:0] FUNC_EN_O,
   output logic HEAT_FROST_OUTDOOR_O,
   output logic INV_TIME_VALID_O,
   output logic STORAGE_TIME_VALID_O
);

   // storage, indexed from the start of the span
   logic [15:0] regs [NUM_REGS];
   hlc_req_t req;
   logic [5:0] idx;
   logic in_span;
   logic reserved;
   hlc_time_t inv_time; // decoded inversion toleration time
   hlc_time_t store_time; // decoded hot-water storage time

   assign req = '{rd: RD_I, wr: WR_I, addr: ADDR_I, wdata: WDATA_I};
   assign in_span = (req.addr >= SPAN_LO) && (req.addr <= SPAN_HI);
   assign idx = 6'(req.addr - SPAN_LO);

   // reserved words are not storage, so writes fall away
   function automatic logic is_reserved(input logic [15:0] a);
      return (a == RESERVED_A_LO) || (a == RESERVED_A_HI) || (a == RESERVED_B);
   endfunction

   // two-bit selector from a word; any high bit makes it unusable
   function automatic logic [1:0] sel2(input logic [15:0] v);
      return (v[15:2] == 14'h0000) ? v[1:0] : 2'h0;
   endfunction

   // single-bit enable; only the value one turns a function on
   function automatic logic en1(input logic [15:0] v);
      return v == 16'h0001;
   endfunction

   // duration decode: all ones means not configured
   function automatic hlc_time_t dur(input logic [15:0] v);
      hlc_time_t t;
      t.configured = (v != NOT_CONFIGURED);
      t.in_range = (v <= TIME_MAX_S);
      t.seconds = v;
      return t;
   endfunction

   // limit response decode; a code beyond two is flagged bad
   function automatic hlc_resp_t resp(input logic [15:0] v);
      hlc_resp_t r;
      unique case (sel2(v))
         2'h0: r = HLC_RESP_LOCKOUT;
         2'h1: r = HLC_RESP_RECYCLE;
         2'h2: r = HLC_RESP_RECYCLE_RETRY;
         default: r = HLC_RESP_BAD;
      endcase
      if (v[15:2] != 14'h0000) begin
         r = HLC_RESP_BAD;
      end
      return r;
   endfunction

   assign reserved = is_reserved(req.addr);

   function automatic logic [15:0] rg(input logic [15:0] a);
      return regs[6'(a - SPAN_LO)];
   endfunction

   // one storage word per address; the priority word keeps only five bits
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         always_ff @(posedge CLK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
               regs[g] <= REG_RESET;
            end else if (req.wr && in_span && !reserved && idx == 6'(g)) begin
               if (16'(g) + SPAN_LO == ANTICOND_PRIORITY_MAP) begin
                  regs[g] <= {11'h000, req.wdata[4:0] & PRIO_MASK};
               end else if (16'(g) + SPAN_LO == RESERVED_A_LO ||
                            16'(g) + SPAN_LO == RESERVED_A_HI ||
                            16'(g) + SPAN_LO == RESERVED_B) begin
                  regs[g] <= REG_RESET;
               end else begin
                  regs[g] <= req.wdata;
               end
            end
         end
      end
   endgenerate

   // read port: one cycle after the strobe
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         RDATA_O <= 16'h0000;
         RVALID_O <= 1'b0;
      end else begin
         RVALID_O <= req.rd;
         if (req.rd && in_span && !reserved) begin
            RDATA_O <= regs[idx];
         end else if (req.rd) begin
            RDATA_O <= 16'h0000;
         end
      end
   end

   // hit flag: access landed on a live word of this bank
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         HIT_O <= 1'b0;
      end else begin
         HIT_O <= (req.rd || req.wr) && in_span && !reserved;
      end
   end

   // delta-t pair and response decode
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         DT_PAIR_XO_O <= 2'h0;
         DT_PAIR_IX_O <= 2'h0;
         INV_RESP_O <= 2'h0;
         RISE_RESP_O <= 2'h0;
         DT_RATE_LIMIT_O <= 1'b0;
      end else begin
         // bit 0 inversion check, bit 1 difference check
         DT_PAIR_XO_O <= sel2(rg(XCHG_OUTLET_DT_EN));
         DT_PAIR_IX_O <= sel2(rg(INLET_XCHG_DT_EN));
         INV_RESP_O <= 2'(resp(rg(INVERSION_RESPONSE)));
         RISE_RESP_O <= 2'(resp(rg(RISE_RESPONSE)));
         DT_RATE_LIMIT_O <= en1(rg(DT_RATE_LIMIT_EN));
      end
   end

   // retry counts pass through; the control counts recycles against them
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         DT_RETRY_O <= 16'h0000;
         RISE_RETRY_O <= 16'h0000;
      end else begin
         DT_RETRY_O <= rg(DT_RETRY_LIMIT);
         RISE_RETRY_O <= rg(RISE_RETRY_LIMIT);
      end
   end

   // anticondensation, pump and priority decode
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ANTICOND_PRIO_O <= 5'h00;
         HEAT_PUMP_OFF_O <= 1'b0;
         WATER_PUMP_OFF_O <= 1'b0;
         WATER_PRIO_DROP_O <= 1'b0;
      end else begin
         ANTICOND_PRIO_O <= 5'(rg(ANTICOND_PRIORITY_MAP));
         HEAT_PUMP_OFF_O <= en1(rg(HEAT_ANTICOND_PUMP_OFF));
         WATER_PUMP_OFF_O <= en1(rg(WATER_ANTICOND_PUMP_OFF));
         WATER_PRIO_DROP_O <= en1(rg(WATER_PRIORITY_METHOD));
      end
   end

   // function enables: heat anticond, water anticond, frost anticond,
   // storage, heat frost, water frost, and the exchanger rise enable
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         FUNC_EN_O <= 7'h00;
         HEAT_FROST_OUTDOOR_O <= 1'b0;
      end else begin
         FUNC_EN_O[0] <= en1(rg(HEAT_ANTICOND_EN));
         FUNC_EN_O[1] <= en1(rg(WATER_ANTICOND_EN));
         FUNC_EN_O[2] <= en1(rg(FROST_ANTICOND_EN));
         FUNC_EN_O[3] <= en1(rg(WATER_STORAGE_EN));
         FUNC_EN_O[4] <= en1(rg(HEAT_FROST_EN));
         FUNC_EN_O[5] <= en1(rg(WATER_FROST_EN));
         FUNC_EN_O[6] <= en1(rg(XCHG_RISE_EN));
         // outdoor frost setpoint steers space heating frost only
         HEAT_FROST_OUTDOOR_O <= en1(rg(HEAT_FROST_EN));
      end
   end

   // decoded durations; split out so the flops below read plain fields
   assign inv_time = dur(rg(INVERSION_TOLERATE_TIME));
   assign store_time = dur(rg(WATER_STORAGE_TIME));

   // durations: valid when configured and within 18 hours
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         INV_TIME_VALID_O <= 1'b0;
         STORAGE_TIME_VALID_O <= 1'b0;
      end else begin
         INV_TIME_VALID_O <= inv_time.in_range;
         STORAGE_TIME_VALID_O <= store_time.configured && store_time.in_range;
      end
   end

   // temperature words are stored as written; range is the master's duty
   // differences 0..DIFF_MAX, setpoints TEMP_MIN..TEMP_MAX

   // write then read of a live word returns it
   sequence s_wr_live;
      WR_I && !RD_I && ADDR_I >= SPAN_LO && ADDR_I <= SPAN_HI && !is_reserved(ADDR_I);
   endsequence
   property p_write_read;
      logic [15:0] a;
      logic [15:0] d;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      (s_wr_live, a = ADDR_I, d = WDATA_I) ##1 (RD_I && !WR_I && ADDR_I == a)
      |=> RDATA_O == ((a == ANTICOND_PRIORITY_MAP) ? {11'h000, d[4:0]} : d);
   endproperty
   a_write_read: assert property (p_write_read) else $error("readback mismatch");

   property p_prio_zero;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      $past(RD_I) && $past(ADDR_I) == ANTICOND_PRIORITY_MAP |-> RDATA_O[15:5] == 11'h000;
   endproperty
   a_prio_zero: assert property (p_prio_zero) else $error("priority high bits set");

   property p_rsvd_zero;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      RD_I && (is_reserved(ADDR_I) || ADDR_I < SPAN_LO || ADDR_I > SPAN_HI)
      |=> RVALID_O && RDATA_O == 16'h0000 && !HIT_O;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved word not zero");

   property p_pair_decode;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      WR_I && ADDR_I == XCHG_OUTLET_DT_EN && WDATA_I == 16'h0003 ##1 !WR_I
      |=> DT_PAIR_XO_O == 2'h3;
   endproperty
   a_pair_decode: assert property (p_pair_decode) else $error("pair enable decode");

   property p_resp_decode;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      WR_I && ADDR_I == RISE_RESPONSE && WDATA_I == 16'h0002 ##1 !WR_I
      |=> RISE_RESP_O == 2'h2;
   endproperty
   a_resp_decode: assert property (p_resp_decode) else $error("response decode");

   property p_unconf;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      WR_I && ADDR_I == WATER_STORAGE_TIME && WDATA_I == NOT_CONFIGURED ##1 !WR_I
      |=> !STORAGE_TIME_VALID_O;
   endproperty
   a_unconf: assert property (p_unconf) else $error("unconfigured time valid");

   property p_pump_off;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      WR_I && ADDR_I == HEAT_ANTICOND_PUMP_OFF ##1 !WR_I
      |=> HEAT_PUMP_OFF_O == ($past(WDATA_I, 2) == 16'h0001);
   endproperty
   a_pump_off: assert property (p_pump_off) else $error("pump force-off decode");

   property p_prio_method;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      WR_I && ADDR_I == WATER_PRIORITY_METHOD ##1 !WR_I
      |=> WATER_PRIO_DROP_O == ($past(WDATA_I, 2) == 16'h0001);
   endproperty
   a_prio_method: assert property (p_prio_method) else $error("priority method decode");

   property p_rvalid;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      RD_I |=> RVALID_O ##1 (RVALID_O == $past(RD_I));
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read valid timing");

   // a write followed by a quiet cycle; decoded outputs settle two edges on
   sequence s_settle(logic [15:0] a);
      WR_I && ADDR_I == a ##1 !WR_I;
   endsequence

   // an idle cycle leaves no read pulse behind
   property p_rvalid_drop;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      !RD_I |=> !RVALID_O;
   endproperty
   a_rvalid_drop: assert property (p_rvalid_drop) else $error("read valid stretched");

   // a write to a live word raises the hit flag
   property p_hit_write;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      s_wr_live |=> HIT_O;
   endproperty
   a_hit_write: assert property (p_hit_write) else $error("write hit missing");

   // retry words pass through untouched
   property p_retry_copy;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      s_settle(DT_RETRY_LIMIT) |=> DT_RETRY_O == $past(WDATA_I, 2);
   endproperty
   a_retry_copy: assert property (p_retry_copy) else $error("retry copy");

   // rate limiting only for the value one
   property p_rate_decode;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      s_settle(DT_RATE_LIMIT_EN) |=> DT_RATE_LIMIT_O == ($past(WDATA_I, 2) == 16'h0001);
   endproperty
   a_rate_decode: assert property (p_rate_decode) else $error("rate limit decode");

   // toleration time valid only up to the 18 hour ceiling
   property p_inv_time;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      s_settle(INVERSION_TOLERATE_TIME)
      |=> INV_TIME_VALID_O == ($past(WDATA_I, 2) <= TIME_MAX_S);
   endproperty
   a_inv_time: assert property (p_inv_time) else $error("toleration time range");

   // each priority bit reaches its own output bit
   property p_prio_map;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      s_settle(ANTICOND_PRIORITY_MAP) |=> ANTICOND_PRIO_O == $past(WDATA_I[4:0], 2);
   endproperty
   a_prio_map: assert property (p_prio_map) else $error("priority map");

   // single enable: heating frost protection on only for one
   property p_frost_en;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      s_settle(HEAT_FROST_EN) |=> FUNC_EN_O[4] == ($past(WDATA_I, 2) == 16'h0001);
   endproperty
   a_frost_en: assert property (p_frost_en) else $error("frost enable decode");

endmodule

// *** test/hlc_master.sv ***
`timescale 1ns/100ps
// serial-bus master stand-in: one-cycle strobes, released lines flip
module hlc_master
   import hlc_pkg::*;
(
   // clock
   input wire logic clk_i,
   // request toward the bank
   output hlc_req_t req_o,
   // answer from the bank
   input wire logic [15:0] rdata_i,
   input wire logic rvalid_i,
   input wire logic hit_i
);
   initial begin
      req_o = '0;
   end
   // release: lines invert so a stale address or data can never pass
   task automatic idle();
      req_o.rd <= 1'b0;
      req_o.wr <= 1'b0;
      req_o.addr <= ~req_o.addr;
      req_o.wdata <= ~req_o.wdata;
   endtask
   // one word written, taken at the following edge
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      req_o.wr <= 1'b1;
      req_o.addr <= a;
      req_o.wdata <= d;
      @(posedge clk_i);
      idle();
   endtask
   // write then read the same word on the very next edge
   task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_i);
      req_o.wr <= 1'b1;
      req_o.addr <= a;
      req_o.wdata <= d;
      @(posedge clk_i);
      req_o.wr <= 1'b0;
      req_o.rd <= 1'b1;
      @(posedge clk_i);
      idle();
      #1;
      q = rdata_i;
   endtask
   // one word read; the answer stands just after the taking edge
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v,
                     output logic h);
      @(posedge clk_i);
      req_o.rd <= 1'b1;
      req_o.addr <= a;
      @(posedge clk_i);
      idle();
      #1;
      d = rdata_i;
      v = rvalid_i;
      h = hit_i;
   endtask
endmodule

// *** test/heating_limit_config_bank_tb_top.sv ***
`timescale 1ns/100ps
module heating_limit_config_bank_tb_top;
   import hlc_pkg::*;
   logic clk;
   logic arst_n;
   hlc_req_t req;
   logic [15:0] rdata, dtr, rtr, wa, wq;
   logic rvalid, hit, rate, hpo, wpo, wdrop, hfo, itv, stv;
   logic [1:0] pxo, pix, iresp, rresp;
   logic [4:0] prio;
   logic [6:0] fen;
   int err_count, checks_done, cycles;
   logic [31:0] lfsr;
   logic [15:0] exp_mem [0:NUM_REGS-1];
   // selector words: pair enables, responses, single bits, then the seven enables
   localparam logic [15:0] SEL [15] = '{XCHG_OUTLET_DT_EN, INLET_XCHG_DT_EN,
      INVERSION_RESPONSE, RISE_RESPONSE, DT_RATE_LIMIT_EN, HEAT_ANTICOND_PUMP_OFF,
      WATER_ANTICOND_PUMP_OFF, WATER_PRIORITY_METHOD, HEAT_ANTICOND_EN, WATER_ANTICOND_EN,
      FROST_ANTICOND_EN, WATER_STORAGE_EN, HEAT_FROST_EN, WATER_FROST_EN, XCHG_RISE_EN};
   localparam logic [15:0] TV [4] = '{16'h0000, 16'hFD20, 16'hFD21, 16'hFFFF};

   hlc_master m_u (.clk_i(clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid), .hit_i(hit));

   hlc_bank dut_u (.CLK_I(clk), .ARST_N_I(arst_n), .RD_I(req.rd), .WR_I(req.wr),
      .ADDR_I(req.addr), .WDATA_I(req.wdata), .RDATA_O(rdata), .RVALID_O(rvalid),
      .HIT_O(hit), .DT_PAIR_XO_O(pxo), .DT_PAIR_IX_O(pix), .INV_RESP_O(iresp),
      .RISE_RESP_O(rresp), .DT_RETRY_O(dtr), .RISE_RETRY_O(rtr), .DT_RATE_LIMIT_O(rate),
      .ANTICOND_PRIO_O(prio), .HEAT_PUMP_OFF_O(hpo), .WATER_PUMP_OFF_O(wpo),
      .WATER_PRIO_DROP_O(wdrop), .FUNC_EN_O(fen), .HEAT_FROST_OUTDOOR_O(hfo),
      .INV_TIME_VALID_O(itv), .STORAGE_TIME_VALID_O(stv));

   // live words answer; reserved gaps and neighbours do not
   function automatic logic live(input logic [15:0] a);
      return a >= SPAN_LO && a <= SPAN_HI && a != RESERVED_A_LO && a != RESERVED_A_HI
         && a != RESERVED_B;
   endfunction
   // what a write leaves behind in a word
   function automatic logic [15:0] stored(input logic [15:0] a, input logic [15:0] d);
      if (!live(a)) return 16'h0000;
      if (a == ANTICOND_PRIORITY_MAP) return {11'h000, d[4:0]};
      return d;
   endfunction
   // decoders; out-of-range codes fall to the safe values chosen for the bank
   function automatic logic [15:0] pair(input logic [15:0] v);
      return (v > 16'h0003) ? 16'h0000 : v;
   endfunction
   function automatic logic [15:0] resp(input logic [15:0] v);
      return (v > 16'h0002) ? 16'h0003 : v;
   endfunction
   function automatic logic [15:0] one(input logic [15:0] v);
      return {15'h0000, v == 16'h0001};
   endfunction
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction

   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic results();
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // read one word and compare data, valid pulse and hit flag
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic v;
      logic h;
      m_u.rd(a, d, v, h);
      chk("rvalid", {15'h0000, v}, 16'h0001);
      chk("rdata", d, exp);
      chk("hit", {15'h0000, h}, {15'h0000, live(a)});
   endtask

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         err_count++;
         results();
      end
   end

   initial begin
      arst_n = 1'b0;
      lfsr = 32'hBBF34F52;
      err_count = 0;
      checks_done = 0;
      cycles = 0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      // after reset every word, and both neighbours outside the span, reads zero
      for (int i = 16'h01E4; i <= 16'h0214; i++) rd_chk(16'(i), 16'h0000);
      // random fill of the whole span, reserved gaps included
      for (int i = 0; i < NUM_REGS; i++) begin
         lfsr = next_rand(lfsr);
         exp_mem[i] = stored(SPAN_LO + 16'(i), lfsr[15:0]);
         m_u.wr(SPAN_LO + 16'(i), lfsr[15:0]);
      end
      m_u.wr(16'h0214, 16'hFFFF);
      for (int i = 0; i < NUM_REGS; i++) rd_chk(SPAN_LO + 16'(i), exp_mem[i]);
      rd_chk(16'h0214, 16'h0000);
      chk("dt_retry", dtr, exp_mem[int'(DT_RETRY_LIMIT - SPAN_LO)]);
      chk("rise_retry", rtr, exp_mem[int'(RISE_RETRY_LIMIT - SPAN_LO)]);
      // back-to-back write and read, priority word first, then random words
      for (int i = 0; i < 8; i++) begin
         lfsr = next_rand(lfsr);
         wa = (i == 0) ? ANTICOND_PRIORITY_MAP : SPAN_LO + (lfsr[31:16] % 16'(NUM_REGS));
         m_u.wr_rd(wa, lfsr[15:0], wq);
         chk("wr_rd", wq, stored(wa, lfsr[15:0]));
      end
      // one priority bit at a time, upper bits always written as ones
      for (int b = 0; b < 5; b++) begin
         m_u.wr(ANTICOND_PRIORITY_MAP, 16'hFFE0 | (16'h0001 << b));
         rd_chk(ANTICOND_PRIORITY_MAP, 16'h0001 << b);
         chk("prio", {11'h000, prio}, 16'h0001 << b);
      end
      // every selector code, plus one code beyond the list
      for (int v = 0; v < 5; v++) begin
         foreach (SEL[k]) m_u.wr(SEL[k], 16'(v));
         rd_chk(XCHG_RISE_EN, 16'(v));
         chk("pair_xo", {14'h0000, pxo}, pair(16'(v)));
         chk("pair_ix", {14'h0000, pix}, pair(16'(v)));
         chk("inv_resp", {14'h0000, iresp}, resp(16'(v)));
         chk("rise_resp", {14'h0000, rresp}, resp(16'(v)));
         chk("rate", {15'h0000, rate}, one(16'(v)));
         chk("heat_pump", {15'h0000, hpo}, one(16'(v)));
         chk("water_pump", {15'h0000, wpo}, one(16'(v)));
         chk("prio_drop", {15'h0000, wdrop}, one(16'(v)));
         chk("func_en", {9'h000, fen}, (v == 1) ? 16'h007F : 16'h0000);
         chk("frost_outdoor", {15'h0000, hfo}, one(16'(v)));
      end
      // duration limits and the unconfigured code
      foreach (TV[k]) begin
         m_u.wr(INVERSION_TOLERATE_TIME, TV[k]);
         m_u.wr(WATER_STORAGE_TIME, TV[k]);
         rd_chk(WATER_STORAGE_TIME, TV[k]);
         chk("inv_time", {15'h0000, itv}, {15'h0000, TV[k] <= TIME_MAX_S});
         chk("store_time", {15'h0000, stv},
             {15'h0000, TV[k] != NOT_CONFIGURED && TV[k] <= TIME_MAX_S});
      end
      // mid-run reset: stored words and decoded outputs return to zero
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      chk("dt_retry_rst", dtr, 16'h0000);
      rd_chk(WATER_STORAGE_TIME, 16'h0000);
      results();
   end
endmodule
